// File: rtl/psr_pkg.sv
// psr_pkg: command codes, field layout, timing and carriers for the spi readout
// assumes a 20 MHz core clock and an spi mode 0/3 master on the far side
package psr_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  // conversion times per oversampling step, in microseconds
  localparam int          CONV_US_256   = 600;
  localparam int          CONV_US_512   = 1170;
  localparam int          CONV_US_1024  = 2280;
  localparam int          CONV_US_2048  = 4540;
  localparam int          CONV_US_4096  = 9040;
  localparam int          CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int          CONV_W        = 18;
  localparam logic [7:0]  CMD_RESET     = 8'h1e;
  localparam logic [7:0]  CMD_ADC_READ  = 8'h00;
  localparam logic [7:0]  CMD_PROM_MASK = 8'hf1;
  localparam logic [7:0]  CMD_PROM_BASE = 8'ha0;
  localparam logic [7:0]  CMD_CONV_MASK = 8'he0;
  localparam logic [7:0]  CMD_CONV_BASE = 8'h40;
  localparam int          CMD_TYP_BIT   = 4;
  localparam int          CMD_OSR_LSB   = 1;
  localparam int          CMD_ADDR_LSB  = 1;
  localparam int          CMD_W         = 8;
  localparam int          ADC_W         = 24;
  localparam int          PROM_W        = 16;
  localparam int          PROM_DEPTH    = 8;
  localparam int          CRC_W         = 4;
  localparam logic [4:0]  ADC_LAST      = 5'h17;
  localparam logic [4:0]  PROM_LAST     = 5'h0f;
  localparam logic [4:0]  CMD_LAST      = 5'h07;
  localparam logic [23:0] ADC_ZERO      = 24'h00_0000;

  typedef enum logic [1:0] {
    PSR_CH_PRESSURE = 2'h0,
    PSR_CH_TEMP     = 2'h1
  } psr_chan_t;

  // conversion request handed from the command decoder to the converter
  typedef struct packed {
    logic      start;
    psr_chan_t chan;
    logic [2:0] osr;
  } psr_conv_req_t;

  // converter status seen by the command logic
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [23:0] value;
  } psr_conv_stat_t;
endpackage

// File: rtl/psr_prom.sv
// psr_prom: eight-word calibration memory, loaded on the reset command
// assumes load is a one-cycle pulse from the command logic
`timescale 1ns/10ps
module psr_prom #(
  parameter logic [15:0] FACTORY_WORD = 16'h0000,  // arbitrary value
  parameter logic [11:0] SERIAL_CODE  = 12'h000,   // arbitrary value
  parameter logic [95:0] COEFFS       = 96'h1234_5678_9abc_def0_1357_2468
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [2:0]  addr,
  output logic [15:0]      word
);
  logic [15:0] mem_q [psr_pkg::PROM_DEPTH];
  logic [15:0] mem_d [psr_pkg::PROM_DEPTH];
  logic [15:0] img   [psr_pkg::PROM_DEPTH];

  // crc-4 over the words with the check nibble held at zero
  function automatic logic [3:0] crc4(input logic [127:0] blk);
    logic [15:0] rem;
    rem = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      rem = rem ^ {8'h00, blk[127 - 8*i -: 8]};
      for (int b = 0; b < 8; b++) begin
        if (rem[15]) begin
          rem = {rem[14:0], 1'b0} ^ 16'h3000;
        end else begin
          rem = {rem[14:0], 1'b0};
        end
      end
    end
    return rem[15:12];
  endfunction

  logic [127:0] flat;
  assign flat = {FACTORY_WORD, COEFFS, SERIAL_CODE, 4'h0};

  genvar g;
  generate
    for (g = 0; g < psr_pkg::PROM_DEPTH - 1; g++) begin : g_img
      assign img[g] = flat[127 - 16*g -: 16];
    end
  endgenerate
  assign img[psr_pkg::PROM_DEPTH-1] = {SERIAL_CODE, crc4(flat)};

  always_comb begin
    for (int i = 0; i < psr_pkg::PROM_DEPTH; i++) begin
      mem_d[i] = load ? img[i] : mem_q[i];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < psr_pkg::PROM_DEPTH; i++) begin
      mem_q[i] <= nrst ? mem_d[i] : 16'h0000;
    end
  end

  assign word = mem_q[addr];
endmodule

// File: rtl/psr_conv.sv
// psr_conv: conversion timer and result source for pressure or temperature
// assumes req.start is a single-cycle pulse; sample inputs stand for the analog front end
`timescale 1ns/10ps
module psr_conv (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  psr_pkg::psr_conv_req_t      req,
  input  wire logic                   corrupt,
  input  wire logic [23:0]            pres_sample,
  input  wire logic [23:0]            temp_sample,
  output psr_pkg::psr_conv_stat_t     stat
);
  logic [psr_pkg::CONV_W-1:0] cnt_q, cnt_d;
  logic                       busy_q, busy_d;
  logic                       bad_q, bad_d;
  logic                       done_q, done_d;
  psr_pkg::psr_chan_t         chan_q, chan_d;
  logic [23:0]                val_q, val_d;
  logic [psr_pkg::CONV_W-1:0] len;

  always_comb begin
    unique case (req.osr)
      3'h0:    len = psr_pkg::CONV_W'(psr_pkg::CONV_US_256  * psr_pkg::CYC_PER_US);
      3'h1:    len = psr_pkg::CONV_W'(psr_pkg::CONV_US_512  * psr_pkg::CYC_PER_US);
      3'h2:    len = psr_pkg::CONV_W'(psr_pkg::CONV_US_1024 * psr_pkg::CYC_PER_US);
      3'h3:    len = psr_pkg::CONV_W'(psr_pkg::CONV_US_2048 * psr_pkg::CYC_PER_US);
      default: len = psr_pkg::CONV_W'(psr_pkg::CONV_US_4096 * psr_pkg::CYC_PER_US);
    endcase
  end

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    bad_d  = bad_q | (busy_q & (corrupt | req.start)); // R5 R6
    done_d = done_q;
    chan_d = chan_q;
    val_d  = val_q;
    if (req.start && !busy_q) begin // R1
      cnt_d  = len;
      busy_d = 1'b1;
      bad_d  = 1'b0;
      done_d = 1'b0;
      chan_d = req.chan;
    end else if (busy_q) begin
      cnt_d = cnt_q - 1'b1;
      if (cnt_q == 1) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        val_d  = (chan_q == psr_pkg::PSR_CH_PRESSURE) ? pres_sample : temp_sample;
        if (bad_d) begin
          val_d = ~val_d; // R5
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      bad_q  <= 1'b0;
      done_q <= 1'b0;
      chan_q <= psr_pkg::PSR_CH_PRESSURE;
      val_q  <= psr_pkg::ADC_ZERO;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      bad_q  <= bad_d;
      done_q <= done_d;
      chan_q <= chan_d;
      val_q  <= val_d;
    end
  end

  assign stat.busy  = busy_q;
  assign stat.done  = done_q;
  assign stat.value = val_q;

  AST_CONV_ENDS: assert property (@(posedge clk) disable iff (!nrst) // R1
    busy_q && cnt_q == 1 |=> !busy_q && done_q)
    else $error("conversion did not finish on count end");
endmodule

// File: rtl/psr_spi_top.sv
// psr_spi_top: spi command decoder and shifter of the pressure sensor readout
// assumes sclk, chip select and serial_in come asynchronously from an spi master
`timescale 1ns/10ps
// Notes on behaviour
// (R1) a convert command starts pressure or temperature conversion as selected
// (R2) conversion keeps running when chip select goes high
// (R3) adc read after conversion shifts the result out msb first
// (R4) adc read without fresh result returns zero
// (R5) adc read during conversion returns zero, conversion continues, result spoiled
// (R6) host must not start conversion while one runs; it spoils the value
// (R7) host reads whole prom once after every reset
// (R8) prom has eight words, 128 bits, chosen by command address
// (R9) word 0 factory, 1 to 6 coefficients, 7 serial and check code
// (R10) each coefficient is a full 16-bit unsigned word
// (R11) prom read is 8-bit command then 16-bit msb-first answer
// (R12) prom holds a 4-bit crc over its contents
// (R13) host sends reset command once after power-up to load prom
// (R14) prom read is command then transfer returning the word
// (R15) adc result is 24 bits, host clocks 24 cycles
// (R16) host holds chip select low over command and answer, msb first
// (R17) host waits the conversion time before adc read
module psr_spi_top (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        chip_select_low,
  input  wire logic        serial_in,
  input  wire logic        protocol_select,
  input  wire logic [23:0] pres_sample,
  input  wire logic [23:0] temp_sample,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  output logic             conv_busy
);
  typedef enum logic [1:0] {
    PSR_ST_CMD  = 2'b00,
    PSR_ST_DATA = 2'b01,
    PSR_ST_DONE = 2'b11
  } psr_state_t;

  // three-stage synchronisers; for sclk and chip select a change counts when stages 2 and 3 agree
  logic [2:0] sclk_s_q, csn_s_q, sdi_s_q;
  logic       sclk_f_q, csn_f_q;
  logic       sclk_f_d, csn_f_d;

  always_comb begin
    sclk_f_d = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
    csn_f_d  = (csn_s_q[1]  == csn_s_q[2])  ? csn_s_q[2]  : csn_f_q;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_s_q <= 3'h0;
      csn_s_q  <= 3'h7;
      sdi_s_q  <= 3'h0;
      sclk_f_q <= 1'b0;
      csn_f_q  <= 1'b1;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      csn_s_q  <= {csn_s_q[1:0], chip_select_low};
      sdi_s_q  <= {sdi_s_q[1:0], serial_in};
      sclk_f_q <= sclk_f_d;
      csn_f_q  <= csn_f_d;
    end
  end

  logic sel, rise, fall;
  assign sel  = !csn_f_q && !protocol_select;
  assign rise = sel && sclk_f_d && !sclk_f_q;
  assign fall = sel && !sclk_f_d && sclk_f_q;

  psr_state_t              st_q, st_d;
  logic [4:0]              bit_q, bit_d;
  logic [7:0]              cmd_q, cmd_d;
  logic [23:0]             sh_q, sh_d;
  logic [4:0]              last_q, last_d;
  logic                    fresh_q, fresh_d;
  logic                    so_q, so_d;
  logic                    oe_n_q, oe_n_d;
  logic                    load_p;
  logic                    rd_busy;
  logic [2:0]              prom_addr;
  logic [15:0]             prom_word;
  psr_pkg::psr_conv_req_t  req;
  psr_pkg::psr_conv_stat_t stat;
  logic                    done_prev_q;
  logic                    done_rise;
  logic [7:0]              cmd_full;

  // a result finishing in the same cycle as a clear stays fresh
  assign done_rise = stat.done & !done_prev_q;

  assign cmd_full  = {cmd_q[6:0], sdi_s_q[2]};
  assign prom_addr = cmd_full[psr_pkg::CMD_ADDR_LSB +: 3];

  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    cmd_d   = cmd_q;
    sh_d    = sh_q;
    last_d  = last_q;
    fresh_d = fresh_q | done_rise;
    so_d    = so_q;
    oe_n_d  = csn_f_q | protocol_select;
    load_p  = 1'b0;
    rd_busy = 1'b0;
    req     = '{start: 1'b0, chan: psr_pkg::PSR_CH_PRESSURE, osr: 3'h0};
    if (!sel) begin
      st_d  = PSR_ST_CMD; // R16
      bit_d = 5'h00;
    end else if (rise) begin
      unique case (st_q)
        PSR_ST_CMD: begin
          cmd_d = cmd_full;
          bit_d = bit_q + 5'h01;
          if (bit_q == psr_pkg::CMD_LAST) begin
            bit_d = 5'h00;
            st_d  = PSR_ST_DONE;
            if (cmd_full == psr_pkg::CMD_RESET) begin
              load_p  = 1'b1; // R13
              fresh_d = done_rise;
            end else if ((cmd_full & psr_pkg::CMD_CONV_MASK) == psr_pkg::CMD_CONV_BASE) begin
              req.start = 1'b1; // R1
              req.chan  = cmd_full[psr_pkg::CMD_TYP_BIT] ?
                          psr_pkg::PSR_CH_TEMP : psr_pkg::PSR_CH_PRESSURE;
              req.osr   = cmd_full[psr_pkg::CMD_OSR_LSB +: 3];
              fresh_d   = done_rise;
            end else if (cmd_full == psr_pkg::CMD_ADC_READ) begin
              st_d   = PSR_ST_DATA;
              last_d = psr_pkg::ADC_LAST; // R15
              // zero unless a finished result is unread
              sh_d   = (fresh_q && !stat.busy) ? stat.value : psr_pkg::ADC_ZERO; // R3 R4 R5
              rd_busy = stat.busy; // R5
              fresh_d = done_rise; // R4
            end else if ((cmd_full & psr_pkg::CMD_PROM_MASK) == psr_pkg::CMD_PROM_BASE) begin
              st_d   = PSR_ST_DATA; // R14
              last_d = psr_pkg::PROM_LAST;
              sh_d   = {prom_word, 8'h00}; // R11
            end
          end
        end
        PSR_ST_DATA: begin
          bit_d = bit_q + 5'h01;
          if (bit_q == last_q) begin
            st_d = PSR_ST_DONE;
          end
        end
        PSR_ST_DONE: begin
          st_d = PSR_ST_DONE;
        end
      endcase
    end else if (fall) begin
      if (st_q == PSR_ST_DATA) begin
        so_d = sh_q[psr_pkg::ADC_W-1]; // R3 R11
        sh_d = {sh_q[psr_pkg::ADC_W-2:0], 1'b0};
      end else begin
        so_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q        <= PSR_ST_CMD;
      bit_q       <= 5'h00;
      cmd_q       <= 8'h00;
      sh_q        <= psr_pkg::ADC_ZERO;
      last_q      <= 5'h00;
      fresh_q     <= 1'b0;
      so_q        <= 1'b0;
      oe_n_q      <= 1'b1;
      done_prev_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      bit_q       <= bit_d;
      cmd_q       <= cmd_d;
      sh_q        <= sh_d;
      last_q      <= last_d;
      fresh_q     <= fresh_d;
      so_q        <= so_d;
      oe_n_q      <= oe_n_d;
      done_prev_q <= stat.done;
    end
  end

  // conversion runs in its own block, independent of chip select
  psr_conv u_conv ( // R2
    .clk         (clk),
    .nrst        (nrst),
    .req         (req),
    .corrupt     (rd_busy),
    .pres_sample (pres_sample),
    .temp_sample (temp_sample),
    .stat        (stat)
  );

  psr_prom u_prom ( // R8 R9 R10 R12
    .clk  (clk),
    .nrst (nrst),
    .load (load_p),
    .addr (prom_addr),
    .word (prom_word)
  );

  logic busy_o_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_o_q <= 1'b0;
    end else begin
      busy_o_q <= stat.busy;
    end
  end

  assign serial_out      = so_q;
  assign serial_out_oe_n = oe_n_q;
  assign conv_busy       = busy_o_q;

  AST_BUSY_THRU_CS: assert property (@(posedge clk) disable iff (!nrst) // R2
    stat.busy && csn_f_q |=> stat.busy || stat.done)
    else $error("conversion disturbed by chip select");
  AST_ADC_ZERO: assert property (@(posedge clk) disable iff (!nrst) // R4
    rise && st_q == PSR_ST_CMD && bit_q == psr_pkg::CMD_LAST &&
    cmd_full == psr_pkg::CMD_ADC_READ && !fresh_q |=> sh_q == psr_pkg::ADC_ZERO)
    else $error("stale adc read not zero");
  AST_ADC_BUSY: assert property (@(posedge clk) disable iff (!nrst) // R5
    rise && st_q == PSR_ST_CMD && bit_q == psr_pkg::CMD_LAST &&
    cmd_full == psr_pkg::CMD_ADC_READ && stat.busy |=> sh_q == psr_pkg::ADC_ZERO && stat.busy)
    else $error("adc read during conversion wrong");
  AST_START: assert property (@(posedge clk) disable iff (!nrst) // R1
    req.start && !stat.busy |=> stat.busy)
    else $error("conversion did not start");
  AST_ONE_READ: assert property (@(posedge clk) disable iff (!nrst) // R4
    rise && st_q == PSR_ST_CMD && bit_q == psr_pkg::CMD_LAST &&
    cmd_full == psr_pkg::CMD_ADC_READ |=> !fresh_q)
    else $error("result still marked fresh after read");
  AST_PROM_LOAD: assert property (@(posedge clk) disable iff (!nrst) // R11
    rise && st_q == PSR_ST_CMD && bit_q == psr_pkg::CMD_LAST &&
    (cmd_full & psr_pkg::CMD_PROM_MASK) == psr_pkg::CMD_PROM_BASE
    |=> sh_q[23:8] == $past(prom_word) && last_q == psr_pkg::PROM_LAST)
    else $error("prom word not loaded");
  AST_OE: assert property (@(posedge clk) disable iff (!nrst) // R16
    csn_f_q |=> serial_out_oe_n)
    else $error("output driven while deselected");
  AST_MSB: assert property (@(posedge clk) disable iff (!nrst) // R3
    fall && st_q == PSR_ST_DATA |=> serial_out == $past(sh_q[23]))
    else $error("output bit not msb first");
endmodule

// File: test/psr_host.sv
// psr_host: behavioural spi mode 0 master standing in for the host controller
// assumes a 20 MHz clk; sclk is 400 ns, moved on clk rising edges, still between frames
`timescale 1ns/10ps
module psr_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      chip_select_low,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  logic last_q;

  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b1;
    last_q = 1'b0;
  end

  // one frame: command byte, then nrd answer bits, sampled late in sclk high
  task automatic xfer(input logic [7:0] cmd, input int nrd, output logic [23:0] rd);
    int i;
    rd = 24'h00_0000;
    chip_select_low <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      serial_in <= cmd[7 - i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    for (i = 0; i < nrd; i++) begin
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      // undriven line shows the inverse of the last bit seen
      last_q = serial_out_oe_n ? ~last_q : serial_out;
      rd = {rd[22:0], last_q};
      @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chip_select_low <= 1'b1;
    serial_in <= ~cmd[0];
    repeat (4) @(posedge clk);
  endtask
endmodule

// File: test/tb.sv
// tb: self-checking bench of the spi readout, driven through the host model
// assumes conversion times as built (osr 256 is 12000 clk) and default prom contents
`timescale 1ns/10ps
module tb;
  localparam logic [23:0] PRES = 24'h5a_c3e1;
  localparam logic [23:0] TEMP = 24'h3b_71d2;
  localparam logic [95:0] COEF = 96'h1234_5678_9abc_def0_1357_2468;

  typedef struct {
    logic [7:0]  cmd;
    int          nrd;
    bit          conv;
    logic [23:0] exp;
  } psr_row_t;

  logic        clk;
  logic        nrst;
  logic        sclk;
  logic        chip_select_low;
  logic        serial_in;
  logic        protocol_select;
  logic [23:0] pres_sample;
  logic [23:0] temp_sample;
  logic        serial_out;
  logic        serial_out_oe_n;
  logic        conv_busy;
  logic [23:0] rd;
  int          errors;
  int          checked;
  int          k;
  int          w;
  psr_row_t    rows [9];

  psr_spi_top dut_u (
    .clk             (clk),
    .nrst            (nrst),
    .sclk            (sclk),
    .chip_select_low (chip_select_low),
    .serial_in       (serial_in),
    .protocol_select (protocol_select),
    .pres_sample     (pres_sample),
    .temp_sample     (temp_sample),
    .serial_out      (serial_out),
    .serial_out_oe_n (serial_out_oe_n),
    .conv_busy       (conv_busy)
  );

  psr_host host_u (
    .clk             (clk),
    .sclk            (sclk),
    .chip_select_low (chip_select_low),
    .serial_in       (serial_in),
    .serial_out      (serial_out),
    .serial_out_oe_n (serial_out_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // busy must be up now and fall within lo..hi clk from here
  task automatic wait_conv(input int lo, input int hi);
    int n;
    n = 0;
    check("busy after convert", 24'h00_0001, {23'h0, conv_busy});
    while (conv_busy !== 1'b0 && n < 13000) begin
      @(posedge clk);
      n++;
    end
    check("conversion length", 24'h00_0001, {23'h0, (n >= lo && n <= hi)});
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    errors = 0;
    checked = 0;
    nrst = 1'b0;
    protocol_select = 1'b0;
    pres_sample = PRES;
    temp_sample = TEMP;
    rows = '{
      '{8'ha2, 16, 1'b0, 24'h00_0000},  // prom empty before load
      '{8'h00, 24, 1'b0, 24'h00_0000},  // read with no conversion
      '{8'h1e, 0, 1'b0, 24'h00_0000},   // load prom
      '{8'h40, 0, 1'b1, 24'h00_0000},   // pressure, osr 256
      '{8'h00, 24, 1'b0, PRES},
      '{8'h00, 24, 1'b0, 24'h00_0000},  // repeated read
      '{8'h50, 0, 1'b1, 24'h00_0000},   // temperature, osr 256
      '{8'h00, 24, 1'b0, TEMP},
      '{8'ha0, 16, 1'b0, 24'h00_0000}   // factory word
    };
    repeat (12) @(posedge clk);
    check("serial_out_oe_n", 24'h00_0001, {23'h0, serial_out_oe_n});
    check("conv_busy", 24'h00_0000, {23'h0, conv_busy});
    check("serial_out", 24'h00_0000, {23'h0, serial_out});
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    for (k = 0; k < 9; k++) begin
      host_u.xfer(rows[k].cmd, rows[k].nrd, rd);
      if (rows[k].conv) begin
        wait_conv(11900, 12010);
      end
      if (rows[k].nrd > 0) begin
        check($sformatf("row %0d", k), rows[k].exp, rd);
      end
    end
    // words 1 to 7 of the calibration memory once after load
    for (w = 1; w < 7; w++) begin
      host_u.xfer(8'ha0 | 8'(w << 1), 16, rd);
      check($sformatf("prom word %0d", w), {8'h0, COEF[95 - 16 * (w - 1) -: 16]}, rd);
    end
    host_u.xfer(8'hae, 16, rd);
    check("prom serial field", 24'h00_0000, {12'h0, rd[15:4]});
    // read while converting: zero, conversion runs on, result spoiled
    host_u.xfer(8'h40, 0, rd);
    host_u.xfer(8'h00, 24, rd);
    check("read during conversion", 24'h00_0000, rd);
    wait_conv(11620, 11745);
    host_u.xfer(8'h00, 24, rd);
    check("spoiled result", ~PRES, rd);
    // each of the ten convert codes (both channels, osr 256 to 4096) starts a conversion; reset cuts it short
    for (k = 0; k < 10; k++) begin
      host_u.xfer(8'h40 | 8'((k / 5) << 4) | 8'((k % 5) << 1), 0, rd);
      check($sformatf("busy for code %0d", k), 24'h00_0001, {23'h0, conv_busy});
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      check("busy after reset", 24'h00_0000, {23'h0, conv_busy});
    end
    host_u.xfer(8'h00, 24, rd);
    check("read after reset", 24'h00_0000, rd);
    wrap_up();
  end
endmodule
